// ===== tape_status_port.v
// tape transport status levels, read character port and register file
`timescale 1ns/100ps
`include "tape_port_defs.vh"
`default_nettype none
module tape_status_port #(
  parameter TRACKS = `TRACKS,
  parameter ADDR_W = `ADDR_W
) (
  input wire sys_clk,
  input wire reset_n,
  // transport mechanics and sensors
  input wire operator_remote,
  input wire unit_selected,
  input wire tape_loaded,
  input wire write_ring_fitted,
  input wire tape_start_marker,
  input wire end_marker_seen,
  input wire char_assembled,
  input wire [TRACKS-1:0] char_bits,
  // commands from the controller side
  input wire motion_fwd_req,
  input wire motion_rev_req,
  input wire rewind_req,
  input wire write_req,
  // status and read port toward the controller
  output reg remote_control_active,
  output reg ready_q,
  output reg at_beginning_position,
  output reg tape_end_sensed,
  output reg write_protected,
  output reg rewind_in_progress,
  output wire read_char_strobe,
  output wire [TRACKS-1:0] read_data,
  // drive outputs toward the tape deck
  output reg motor_fwd_q,
  output reg motor_rev_q,
  output reg motor_fast_q,
  output reg write_enable_q,
  // register port
  input wire [ADDR_W-1:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  output reg irq_q
);

  ////////////////////////////////////////////////////////////////////////////
  // internal state

  reg [`CTRL_W-1:0] ctrl_q;
  reg [`IRQ_W-1:0] irq_stat_q;
  reg [`IRQ_W-1:0] irq_mask_q;
  reg [`IRQ_W-1:0] irq_event;
  reg [TRACKS-1:0] last_char_q;
  reg end_prev_q;
  reg ready_prev_q;
  reg sw_rewind_q;
  wire rw_rev;
  wire rw_fwd;
  wire rw_fast;
  wire rw_active;
  wire rw_done;
  wire ch_overrun;
  wire ch_sent;
  wire ready_d;
  wire protect_d;
  wire rewind_start;
  wire wr_hit;
  wire rd_hit;
  // strobe timing in cycles, cut on purpose to the sequencer's 16-bit counter
  localparam integer SETUP_LEN = `SETUP_CYC;
  localparam integer PULSE_LEN = `STROBE_CYC;
  localparam integer HOLD_LEN = `HOLD_CYC;

  ////////////////////////////////////////////////////////////////////////////
  // status levels

  // ready drops the cycle a rewind begins, ahead of any motion request
  assign ready_d = operator_remote && unit_selected && tape_loaded
    && !rw_active;
  assign protect_d = !write_ring_fitted;

  always @(posedge sys_clk) begin
    if (!reset_n) begin
      remote_control_active <= 1'b0;
      ready_q <= 1'b0;
      at_beginning_position <= 1'b0;
      tape_end_sensed <= 1'b0;
      write_protected <= 1'b0;
      rewind_in_progress <= 1'b0;
      end_prev_q <= 1'b0;
      ready_prev_q <= 1'b0;
    end else begin
      remote_control_active <= operator_remote;
      ready_q <= ready_d;
      // only true once the deck has settled on the marker
      at_beginning_position <= tape_start_marker && !rw_active;
      // passed straight through, no debounce: edge chatter is left visible
      tape_end_sensed <= end_marker_seen;
      write_protected <= protect_d;
      rewind_in_progress <= rw_active;
      end_prev_q <= end_marker_seen;
      ready_prev_q <= ready_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // rewind sequencing

  // a rewind is only taken under remote control and selection
  assign rewind_start = (rewind_req || sw_rewind_q) && operator_remote
    && unit_selected && tape_loaded;

  rewind_seq u_rewind (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .start(rewind_start),
    .abort(!tape_loaded),
    .marker(tape_start_marker),
    .drive_rev_q(rw_rev),
    .drive_fwd_q(rw_fwd),
    .fast_q(rw_fast),
    .active_q(rw_active),
    .done_q(rw_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // motion and write gating

  always @(posedge sys_clk) begin
    if (!reset_n) begin
      motor_fwd_q <= 1'b0;
      motor_rev_q <= 1'b0;
      motor_fast_q <= 1'b0;
      write_enable_q <= 1'b0;
    end else if (rw_active) begin
      motor_fwd_q <= rw_fwd;
      motor_rev_q <= rw_rev;
      motor_fast_q <= rw_fast;
      write_enable_q <= 1'b0;
    end else begin
      // conflicting requests stop the tape rather than pick a direction
      motor_fwd_q <= ready_q && motion_fwd_req && !motion_rev_req;
      motor_rev_q <= ready_q && motion_rev_req && !motion_fwd_req
        && !tape_start_marker;
      motor_fast_q <= 1'b0;
      write_enable_q <= ready_q && write_req && !write_protected
        && !protect_d && !ctrl_q[`CTRL_WINH]
        && (motion_fwd_req ^ motion_rev_req);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read character port

  char_strobe_gen #(
    .DATA_W(TRACKS),
    .CNT_W(16),
    .SETUP_CYC(SETUP_LEN[15:0]),
    .PULSE_CYC(PULSE_LEN[15:0]),
    .HOLD_CYC(HOLD_LEN[15:0])
  ) u_strobe (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .char_valid(char_assembled),
    .char_in(char_bits),
    .data_q(read_data),
    .strobe_q(read_char_strobe),
    .overrun_q(ch_overrun),
    .sent_q(ch_sent)
  );

  always @(posedge sys_clk) begin
    if (!reset_n) begin
      last_char_q <= {TRACKS{1'b0}};
    end else if (ch_sent) begin
      last_char_q <= read_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt events

  always @* begin
    irq_event = {`IRQ_W{1'b0}};
    irq_event[`IRQ_CHAR] = ch_sent;
    irq_event[`IRQ_OVERRUN] = ch_overrun;
    irq_event[`IRQ_END] = end_marker_seen && !end_prev_q;
    irq_event[`IRQ_RWDONE] = rw_done;
    irq_event[`IRQ_UNREADY] = ready_prev_q && !ready_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // register port

  assign wr_hit = reg_wr && !reg_rd;
  assign rd_hit = reg_rd && !reg_wr;

  always @(posedge sys_clk) begin
    if (!reset_n) begin
      ctrl_q <= `CTRL_RST;
      irq_mask_q <= {`IRQ_W{1'b0}};
      irq_stat_q <= {`IRQ_W{1'b0}};
      sw_rewind_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      sw_rewind_q <= 1'b0;
      if (wr_hit && reg_addr == `REG_CTRL) begin
        ctrl_q[`CTRL_WINH] <= reg_wdata[`CTRL_WINH];
        // rewind bit is a self-clearing command, reads back zero
        sw_rewind_q <= reg_wdata[`CTRL_REWIND];
      end
      if (wr_hit && reg_addr == `REG_IRQ_MASK) begin
        irq_mask_q <= reg_wdata[`IRQ_W-1:0];
      end
      // new event beats a same-cycle write-one clear
      if (wr_hit && reg_addr == `REG_IRQ_STAT) begin
        irq_stat_q <= (irq_stat_q & ~reg_wdata[`IRQ_W-1:0]) | irq_event;
      end else begin
        irq_stat_q <= irq_stat_q | irq_event;
      end
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  always @(posedge sys_clk) begin
    if (!reset_n) begin
      reg_rdata <= 32'h00000000;
    end else if (rd_hit) begin
      case (reg_addr)
        `REG_CTRL: reg_rdata <= {{(32-`CTRL_W){1'b0}}, 1'b0,
          ctrl_q[`CTRL_WINH]};
        `REG_STAT: reg_rdata <= {{(32-`STAT_W){1'b0}}, 1'b0,
          write_enable_q, read_char_strobe, rewind_in_progress,
          write_protected, tape_end_sensed, at_beginning_position,
          ready_q};
        `REG_IRQ_STAT: reg_rdata <= {{(32-`IRQ_W){1'b0}}, irq_stat_q};
        `REG_IRQ_MASK: reg_rdata <= {{(32-`IRQ_W){1'b0}}, irq_mask_q};
        `REG_CHAR: reg_rdata <= {{(32-TRACKS){1'b0}}, last_char_q};
        default: reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule // tape_status_port
`default_nettype wire

// ===== tape_port_defs.vh
// constants of the tape transport status and read port
`ifndef TAPE_PORT_DEFS_VH
`define TAPE_PORT_DEFS_VH
`define CLK_NS 10
`define STROBE_NS 2000
`define SETUP_NS 100
`define HOLD_NS 100
`define STROBE_CYC (`STROBE_NS / `CLK_NS)
`define SETUP_CYC ((`SETUP_NS + `CLK_NS - 1) / `CLK_NS)
`define HOLD_CYC ((`HOLD_NS + `CLK_NS - 1) / `CLK_NS)
`define TRACKS 9
`define ADDR_W 8
`define REG_CTRL 8'h00
`define REG_STAT 8'h04
`define REG_IRQ_STAT 8'h08
`define REG_IRQ_MASK 8'h0C
`define REG_CHAR 8'h10
`define CTRL_W 2
`define CTRL_RST 2'h0
`define CTRL_WINH 0
`define CTRL_REWIND 1
`define IRQ_W 5
`define IRQ_CHAR 0
`define IRQ_OVERRUN 1
`define IRQ_END 2
`define IRQ_RWDONE 3
`define IRQ_UNREADY 4
`define STAT_W 8
`endif

// ===== char_strobe_gen.v
// read character strobe sequencer: setup, pulse, hold
`timescale 1ns/100ps
`default_nettype none
module char_strobe_gen #(
  parameter DATA_W = 9,
  parameter CNT_W = 16,
  parameter [CNT_W-1:0] SETUP_CYC = 16'h000A,
  parameter [CNT_W-1:0] PULSE_CYC = 16'h00C8,
  parameter [CNT_W-1:0] HOLD_CYC = 16'h000A
) (
  input wire sys_clk,
  input wire reset_n,
  input wire char_valid,
  input wire [DATA_W-1:0] char_in,
  output reg [DATA_W-1:0] data_q,
  output reg strobe_q,
  output reg overrun_q,
  output reg sent_q
);
  localparam IDLE = 2'b00;
  localparam SETUP = 2'b01;
  localparam PULSE = 2'b10;
  localparam HOLD = 2'b11;
  reg [1:0] state_q;
  reg [CNT_W-1:0] cnt_q;
  wire last = (cnt_q == {{(CNT_W-1){1'b0}}, 1'b1});
  always @(posedge sys_clk) begin
    sent_q <= 1'b0;
    overrun_q <= 1'b0;
    if (!reset_n) begin
      state_q <= IDLE;
      cnt_q <= {CNT_W{1'b0}};
      data_q <= {DATA_W{1'b0}};
      strobe_q <= 1'b0;
    end else begin
      case (state_q)
        IDLE: begin
          if (char_valid) begin
            // data change only here, so lines never move under the pulse
            data_q <= char_in;
            cnt_q <= SETUP_CYC;
            state_q <= SETUP;
          end
        end
        SETUP: begin
          overrun_q <= char_valid;
          cnt_q <= cnt_q - 1'b1;
          if (last) begin
            strobe_q <= 1'b1;
            cnt_q <= PULSE_CYC;
            state_q <= PULSE;
          end
        end
        PULSE: begin
          overrun_q <= char_valid;
          cnt_q <= cnt_q - 1'b1;
          if (last) begin
            strobe_q <= 1'b0;
            sent_q <= 1'b1;
            cnt_q <= HOLD_CYC;
            state_q <= HOLD;
          end
        end
        HOLD: begin
          overrun_q <= char_valid;
          cnt_q <= cnt_q - 1'b1;
          if (last) begin
            state_q <= IDLE;
          end
        end
        default: begin
          state_q <= IDLE;
        end
      endcase
    end
  end
endmodule // char_strobe_gen
`default_nettype wire

// ===== rewind_seq.v
// rewind sequencer: fast back past the marker, forward onto it
`timescale 1ns/100ps
`default_nettype none
module rewind_seq (
  input wire sys_clk,
  input wire reset_n,
  input wire start,
  input wire abort,
  input wire marker,
  output reg drive_rev_q,
  output reg drive_fwd_q,
  output reg fast_q,
  output reg active_q,
  output reg done_q
);
  localparam IDLE = 2'b00;
  localparam BACK = 2'b01;
  localparam PAST = 2'b10;
  localparam FWD = 2'b11;
  reg [1:0] state_q;
  reg [1:0] state_d;
  always @* begin
    state_d = state_q;
    case (state_q)
      IDLE: if (start && !marker) state_d = BACK;
      BACK: if (marker) state_d = PAST;
      PAST: if (!marker) state_d = FWD;
      FWD: if (marker) state_d = IDLE;
      default: state_d = IDLE;
    endcase
    if (abort) state_d = IDLE;
  end
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      state_q <= IDLE;
      drive_rev_q <= 1'b0;
      drive_fwd_q <= 1'b0;
      fast_q <= 1'b0;
      active_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      drive_rev_q <= (state_d == BACK) || (state_d == PAST);
      fast_q <= (state_d == BACK) || (state_d == PAST);
      drive_fwd_q <= (state_d == FWD);
      active_q <= (state_d != IDLE);
      done_q <= (state_q == FWD) && (state_d == IDLE) && !abort;
    end
  end
endmodule // rewind_seq
`default_nettype wire

// ===== tape_port_checker_assertions.sv
// assertion checker of the tape status and read port
`timescale 1ns/100ps
`default_nettype none
`include "tape_port_defs.vh"
module tape_port_checker #(
  parameter TRACKS = 9
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic operator_remote,
  input wire logic unit_selected,
  input wire logic tape_loaded,
  input wire logic write_ring_fitted,
  input wire logic tape_start_marker,
  input wire logic end_marker_seen,
  input wire logic char_assembled,
  input wire logic [TRACKS-1:0] char_bits,
  input wire logic remote_control_active,
  input wire logic ready_q,
  input wire logic at_beginning_position,
  input wire logic tape_end_sensed,
  input wire logic write_protected,
  input wire logic rewind_in_progress,
  input wire logic read_char_strobe,
  input wire logic [TRACKS-1:0] read_data,
  input wire logic motor_fwd_q,
  input wire logic motor_rev_q,
  input wire logic motor_fast_q,
  input wire logic write_enable_q
);
  localparam int PULSE = `STROBE_CYC;
  logic [8:0] cnt_q;
  //////////////////////////////
  // strobe length; wraps only if the strobe sticks
  always @(posedge sys_clk) begin
    if (!reset_n) cnt_q <= 9'h000;
    else cnt_q <= read_char_strobe ? cnt_q + 9'h001 : 9'h000;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  //////////////////////////////
  remote_follow_a: assert property ($past(reset_n) |->
    remote_control_active == $past(operator_remote)) else $error("remote level wrong");
  // ready and the rewind level come out of the same edge, so they never overlap
  ready_gate_a: assert property (ready_q |-> !rewind_in_progress &&
    $past(operator_remote && unit_selected && tape_loaded))
    else $error("ready without its conditions");
  motion_gate_a: assert property (($rose(motor_fwd_q) || $rose(motor_rev_q)) &&
    !rewind_in_progress |-> $past(ready_q)) else $error("motion while not ready");
  begin_pos_a: assert property ($past(reset_n) |-> at_beginning_position ==
    ($past(tape_start_marker) && !rewind_in_progress)) else $error("start position wrong");
  end_protect_a: assert property ($past(reset_n) |-> tape_end_sensed ==
    $past(end_marker_seen) && write_protected == !$past(write_ring_fitted))
    else $error("end or protect level wrong");
  no_write_a: assert property (write_enable_q |-> !write_protected)
    else $error("write while protected");
  strobe_len_a: assert property ($past(reset_n) && $fell(read_char_strobe) |->
    cnt_q == PULSE) else $error("strobe width wrong");
  char_match_a: assert property ($rose(read_char_strobe) |->
    $past(char_assembled, 11) && read_data == $past(char_bits, 11))
    else $error("strobe without its character");
  data_hold_a: assert property ($past(reset_n) &&
    (read_char_strobe || $fell(read_char_strobe)) |-> $stable(read_data))
    else $error("read data moved under strobe");
  rewind_write_a: assert property (rewind_in_progress |-> !write_enable_q)
    else $error("write during rewind");
  cover property ($rose(read_char_strobe));
  cover property ($fell(rewind_in_progress));
  cover property ($rose(write_enable_q));
  cover property ($rose(tape_end_sensed));
endmodule // tape_port_checker
bind tape_status_port tape_port_checker #(.TRACKS(TRACKS)) chk_u (.sys_clk, .reset_n,
  .operator_remote, .unit_selected, .tape_loaded, .write_ring_fitted, .tape_start_marker,
  .end_marker_seen, .char_assembled, .char_bits, .remote_control_active, .ready_q,
  .at_beginning_position, .tape_end_sensed, .write_protected, .rewind_in_progress,
  .read_char_strobe, .read_data, .motor_fwd_q, .motor_rev_q, .motor_fast_q, .write_enable_q);
`default_nettype wire

// ===== tape_ctrl_model.sv
// controller side model: takes each read character on its strobe
`timescale 1ns/100ps
`default_nettype none
module tape_ctrl_model (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic read_char_strobe,
  input wire logic [8:0] read_data,
  input wire logic tape_end_sensed,
  output var logic [8:0] cap_q,
  output var logic [7:0] n_q,
  output var logic end_seen_q
);
  logic seen_q;
  // strobe is the only qualifier; lines between pulses are ignored
  always @(posedge sys_clk) begin
    seen_q <= read_char_strobe;
    // sticky: chatter at the marker edge must not undo the end condition
    end_seen_q <= reset_n && (end_seen_q || tape_end_sensed);
    if (!reset_n) begin
      n_q <= 8'h00;
      cap_q <= 9'h000;
    end else if (read_char_strobe && !seen_q) begin
      cap_q <= read_data;
      n_q <= n_q + 8'h01;
    end
  end
endmodule // tape_ctrl_model
`default_nettype wire

// ===== test_tape_status_port.sv
// random and directed bench of the tape status and read port
`timescale 1ns/100ps
`default_nettype none
`include "tape_port_defs.vh"
module test_tape_status_port;
  logic sys_clk = 1'h0;
  logic reset_n = 1'h0;
  logic char_assembled = 1'h0;
  logic rewind_req = 1'h0;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic [9:0] v = 10'h000;
  logic [9:0] r;
  logic [8:0] char_bits = 9'h000;
  logic [8:0] cap;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] n0;
  logic [7:0] exp_lv;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] d;
  int n_mismatch = 0;
  int checks = 0;
  int i;
  int w;
  wire [8:0] read_data;
  wire [8:0] cap_q;
  wire [7:0] n_q;
  wire end_seen_q;
  wire [31:0] reg_rdata;
  wire remote_control_active, ready_q, at_beginning_position, tape_end_sensed;
  wire write_protected, rewind_in_progress, read_char_strobe, motor_fwd_q;
  wire motor_rev_q, motor_fast_q, write_enable_q, irq_q;
  wire [7:0] lvs = {write_enable_q, motor_rev_q, motor_fwd_q, at_beginning_position,
    write_protected, tape_end_sensed, ready_q, remote_control_active};
  tape_status_port dut_u (.sys_clk, .reset_n, .operator_remote(v[9]), .unit_selected(v[8]),
    .tape_loaded(v[7]), .write_ring_fitted(v[6]), .tape_start_marker(v[5]),
    .end_marker_seen(v[4]), .char_assembled, .char_bits, .motion_fwd_req(v[3]),
    .motion_rev_req(v[2]), .rewind_req, .write_req(v[1]), .remote_control_active, .ready_q,
    .at_beginning_position, .tape_end_sensed, .write_protected, .rewind_in_progress,
    .read_char_strobe, .read_data, .motor_fwd_q, .motor_rev_q, .motor_fast_q,
    .write_enable_q, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq_q);
  tape_ctrl_model partner_u (.sys_clk, .reset_n, .read_char_strobe, .read_data,
    .tape_end_sensed, .cap_q, .n_q, .end_seen_q);
  always #5 sys_clk = ~sys_clk;
  //////////////////////////////
  task tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] x);
    reg_addr <= a;
    reg_wdata <= x;
    reg_wr <= 1'h1;
    tick(1);
    reg_wr <= 1'h0;
    tick(1);
  endtask
  // data stand one cycle only, so they are taken right after the read edge
  task rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'h1;
    tick(1);
    reg_rd <= 1'h0;
    d = reg_rdata;
    tick(1);
  endtask
  task results;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // levels in the order of lvs; x is remote sel load ring mark end fwd rev wreq inhibit
  function automatic logic [7:0] lv(input logic [9:0] x);
    logic rdy;
    rdy = x[9] & x[8] & x[7];
    return {rdy & x[1] & x[6] & !x[0] & (x[3] ^ x[2]), rdy & x[2] & !x[3] & !x[5],
      rdy & x[3] & !x[2], x[5], !x[6], x[4], rdy, x[9]};
  endfunction
  initial begin
    #300000;
    n_mismatch++;
    results;
  end
  //////////////////////////////
  initial begin
    void'($urandom(32'h69FA2368));
    tick(12);
    chk("reset levels", {lvs, rewind_in_progress, read_char_strobe, irq_q}, 11'h000);
    reset_n <= 1'h1;
    tick(1);
    rd(8'h20);
    chk("unmapped", d, 32'h0);
    for (i = 0; i < 40; i++) begin
      r = i == 0 ? 10'h3DE : i == 1 ? 10'h3CA : 10'($urandom);
      r[1] = r[1] & !r[5];
      v <= r;
      wr(`REG_CTRL, {31'h0, r[0]});
      tick(2);
      exp_lv = lv(r);
      chk("levels", lvs, exp_lv);
      rd(`REG_STAT);
      chk("status", d, {25'h0, exp_lv[7], 2'h0, exp_lv[3], exp_lv[2], exp_lv[4], exp_lv[1]});
      rd(`REG_CTRL);
      chk("ctrl", d, {31'h0, r[0]});
    end
    v <= 10'h3C0;
    tick(3);
    wr(`REG_IRQ_STAT, 32'h1F);
    for (i = 0; i < 3; i++) begin
      cap = i == 0 ? 9'h1FF : 9'($urandom);
      n0 = n_q;
      char_bits <= cap;
      char_assembled <= 1'h1;
      tick(1);
      char_assembled <= 1'h0;
      char_bits <= ~cap;
      for (w = 0; w < 30 && read_char_strobe !== 1'h1; w++) tick(1);
      chk("data", read_data, cap);
      w = 0;
      if (i == 2) begin
        char_assembled <= 1'h1;
        tick(1);
        char_assembled <= 1'h0;
        w = 1;
      end
      while (read_char_strobe === 1'h1 && w < 300) begin
        tick(1);
        w++;
      end
      chk("width", w, `STROBE_CYC);
      chk("held", read_data, cap);
      tick(30);
      chk("partner", {n_q - n0, cap_q}, {8'h01, cap});
      rd(`REG_CHAR);
      chk("char reg", d, cap);
    end
    rd(`REG_IRQ_STAT);
    chk("irq stat", d, 32'h3);
    wr(`REG_IRQ_MASK, 32'h1);
    chk("irq on", irq_q, 1'h1);
    wr(`REG_IRQ_STAT, 32'h1);
    chk("irq off", irq_q, 1'h0);
    wr(`REG_IRQ_MASK, 32'h8);
    v <= 10'h3C2;
    tick(3);
    rewind_req <= 1'h1;
    tick(1);
    rewind_req <= 1'h0;
    tick(3);
    chk("rewind", {rewind_in_progress, motor_rev_q, motor_fast_q, ready_q, write_enable_q},
      5'h1C);
    v <= 10'h3CA;
    tick(3);
    chk("motion", motor_fwd_q, 1'h0);
    v <= 10'h3E0;
    tick(4);
    chk("past marker", {at_beginning_position, rewind_in_progress, motor_rev_q}, 3'h3);
    v <= 10'h3C0;
    tick(4);
    chk("advance", {rewind_in_progress, motor_fwd_q, motor_rev_q}, 3'h6);
    v <= 10'h3E0;
    for (w = 0; w < 20 && rewind_in_progress !== 1'h0; w++) tick(1);
    tick(2);
    chk("loaded", {rewind_in_progress, at_beginning_position, motor_fwd_q, irq_q}, 4'h5);
    rewind_req <= 1'h1;
    tick(1);
    rewind_req <= 1'h0;
    tick(3);
    chk("at marker", rewind_in_progress, 1'h0);
    v <= 10'h3C0;
    tick(2);
    wr(`REG_CTRL, 32'h2);
    tick(2);
    chk("sw rewind", {rewind_in_progress, motor_rev_q, motor_fast_q}, 3'h7);
    v <= 10'h340;
    tick(3);
    chk("abort", {rewind_in_progress, motor_rev_q, ready_q}, 3'h0);
    for (i = 0; i < 4; i++) begin
      v[4] <= ~v[4];
      tick(1);
      chk("end chatter", tape_end_sensed, v[4]);
    end
    chk("partner end", end_seen_q, 1'h1);
    rd(`REG_IRQ_STAT);
    chk("irq final", d, 32'h1E);
    results;
  end
endmodule // test_tape_status_port
`default_nettype wire
